// [rtl/opm_port.sv]
// Notes on behaviour
// RULE1: with bit-bang selected the receive input is only a sampled gpio that also feeds the third software uart.
// RULE2: duty select 00/01/10/11 makes the carrier low for 1/2, 1/4, 1/8, 1/16 of its period.
// RULE3: receive pin is uart input when disable and segment map are 0, gpio when only disable is 1, else segment.
// RULE4: receive inversion acts on the uart input only, never on the gpio value.
// RULE5: without segment map the transmit select routes gpio, uart, real-energy pulse or voltage pulse; with it, segment.
// RULE6: transmit inversion is applied before the modulation stage.
// RULE7: with modulation on, the inverted transmit signal is replaced by the carrier wherever it is zero.
// RULE8: energy pulses on the transmit pin are active low unless pulse polarity control is set.
// RULE9: the carrier comes from the system clock through a divider whose period is a parameter.
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
module opm_port
  import opm_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [DATA_W-1:0] reg_rdata,
  // transmit sources
  input  wire logic              uart_txd,
  input  wire logic              real_energy_pulse,
  input  wire logic              voltage_pulse,
  input  wire logic              transmit_pin_gpio_out,
  input  wire logic              transmit_pin_gpio_oe,
  input  wire logic              transmit_pin_segment,
  // transmit pin
  output logic                   optical_transmit_pin_out,
  output logic                   optical_transmit_pin_oe,
  // receive pin
  input  wire logic              optical_receive_pin_in,
  output logic                   optical_receive_pin_out,
  output logic                   optical_receive_pin_oe,
  // receive users
  input  wire logic              receive_pin_gpio_out,
  input  wire logic              receive_pin_gpio_oe,
  input  wire logic              receive_pin_segment,
  output logic                   receive_pin_gpio_in,
  output logic                   uart_rxd,
  output logic                   third_uart_gpio_in
);

  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic [7:0] tx_cfg_reg;
  logic [7:0] rx_cfg_reg;
  logic [7:0] pulse_cfg_reg;
  logic [7:0] seg_map_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rd_mux;
  logic [7:0] status_word;

  logic       sel_tx_cfg;
  logic       sel_rx_cfg;
  logic       sel_pulse_cfg;
  logic       sel_seg_map;
  logic       sel_status;

  assign sel_tx_cfg    = (reg_addr == OPM_TX_CFG_ADDR);
  assign sel_rx_cfg    = (reg_addr == OPM_RX_CFG_ADDR);
  assign sel_pulse_cfg = (reg_addr == OPM_PULSE_CFG_ADDR);
  assign sel_seg_map   = (reg_addr == OPM_SEG_MAP_ADDR);
  assign sel_status    = (reg_addr == OPM_STATUS_ADDR);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_cfg_reg    <= TX_CFG_RST;
      rx_cfg_reg    <= RX_CFG_RST;
      pulse_cfg_reg <= PULSE_CFG_RST;
      seg_map_reg   <= SEG_MAP_RST;
    end else if (reg_write) begin
      if (sel_tx_cfg) begin
        tx_cfg_reg <= reg_wdata & TX_CFG_MASK;
      end
      if (sel_rx_cfg) begin
        rx_cfg_reg <= reg_wdata & RX_CFG_MASK;
      end
      if (sel_pulse_cfg) begin
        pulse_cfg_reg <= reg_wdata & PULSE_CFG_MASK;
      end
      if (sel_seg_map) begin
        seg_map_reg <= reg_wdata & SEG_MAP_MASK;
      end
    end
  end

  // unmapped addresses read as zero; data stands one cycle only
  assign rd_mux = sel_tx_cfg    ? tx_cfg_reg    :
                  sel_rx_cfg    ? rx_cfg_reg    :
                  sel_pulse_cfg ? pulse_cfg_reg :
                  sel_seg_map   ? seg_map_reg   :
                  sel_status    ? status_word   : 8'h00;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= reg_read ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // fields
  logic       tx_inv;
  logic       tx_mod;
  logic [1:0] tx_route;
  logic       rx_bb;
  logic       rx_inv;
  logic       rx_dis;
  logic [1:0] duty_sel;
  logic       pls_pol;
  logic       seg_tx;
  logic       seg_rx;

  assign tx_inv   = tx_cfg_reg[TX_INV_BIT];
  assign tx_mod   = tx_cfg_reg[TX_MOD_BIT];
  assign tx_route = tx_cfg_reg[TX_ROUTE_LSB +: 2];
  assign rx_bb    = rx_cfg_reg[RX_BB_BIT];
  assign rx_inv   = rx_cfg_reg[RX_INV_BIT];
  assign rx_dis   = rx_cfg_reg[RX_DIS_BIT];
  assign duty_sel = rx_cfg_reg[RX_DUTY_LSB +: 2];
  assign pls_pol  = pulse_cfg_reg[PLS_POL_BIT];
  assign seg_tx   = seg_map_reg[SEG_TX_BIT];
  assign seg_rx   = seg_map_reg[SEG_RX_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // carrier and receive synchroniser
  opm_carrier_if cif ();

  assign cif.duty_sel = duty_sel;

  opm_carrier u_carrier (
    .clk    (clk),
    .resetn (resetn),
    .cif    (cif)
  );

  logic rx_sync;

  // comparator output is asynchronous to clk
  opm_sync u_rx_sync (
    .clk      (clk),
    .resetn   (resetn),
    .async_in (optical_receive_pin_in),
    .sync_out (rx_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // transmit path
  logic tx_uart_inv;
  logic tx_uart_mod;
  logic real_pol;
  logic volt_pol;
  logic tx_out_next;
  logic tx_oe_next;
  logic tx_out_reg;
  logic tx_oe_reg;

  assign tx_uart_inv = uart_txd ^ tx_inv; // [RULE6]
  // carrier only fills the zero intervals; ones pass through
  assign tx_uart_mod = tx_mod ? (tx_uart_inv | cif.carrier) : tx_uart_inv; // [RULE7]
  // pulses arrive active high and leave active low by default
  assign real_pol    = pls_pol ? real_energy_pulse : ~real_energy_pulse; // [RULE8]
  assign volt_pol    = pls_pol ? voltage_pulse : ~voltage_pulse; // [RULE8]

  assign tx_out_next = seg_tx                      ? transmit_pin_segment  : // [RULE5]
                       (tx_route == OPM_ROUTE_GPIO) ? transmit_pin_gpio_out :
                       (tx_route == OPM_ROUTE_UART) ? tx_uart_mod           :
                       (tx_route == OPM_ROUTE_REAL) ? real_pol              : volt_pol;
  assign tx_oe_next  = seg_tx || (tx_route != OPM_ROUTE_GPIO) || transmit_pin_gpio_oe; // [RULE5]

  // one register stage keeps the pin free of decode glitches
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_out_reg <= 1'b0;
      tx_oe_reg  <= 1'b0;
    end else begin
      tx_out_reg <= tx_out_next;
      tx_oe_reg  <= tx_oe_next;
    end
  end

  assign optical_transmit_pin_out = tx_out_reg;
  assign optical_transmit_pin_oe  = tx_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // receive path
  opm_rx_mode_t rx_mode;
  logic         rx_out_next;
  logic         rx_oe_next;
  logic         rx_out_reg;
  logic         rx_oe_reg;
  logic         uart_rxd_reg;
  logic         third_rx_reg;

  assign rx_mode = seg_rx ? OPM_RX_SEGMENT : // [RULE3]
                   rx_dis ? OPM_RX_GPIO    :
                   rx_bb  ? OPM_RX_BITBANG : OPM_RX_UART; // [RULE1]

  always_comb begin
    rx_out_next = 1'b0;
    rx_oe_next  = 1'b0;
    case (rx_mode)
      OPM_RX_SEGMENT: begin
        rx_out_next = receive_pin_segment;
        rx_oe_next  = 1'b1;
      end
      OPM_RX_GPIO: begin
        rx_out_next = receive_pin_gpio_out;
        rx_oe_next  = receive_pin_gpio_oe;
      end
      default: begin
        rx_out_next = 1'b0;
        rx_oe_next  = 1'b0;
      end
    endcase
  end

  // uart sees idle high whenever the pin is not its input
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_out_reg   <= 1'b0;
      rx_oe_reg    <= 1'b0;
      uart_rxd_reg <= 1'b1;
      third_rx_reg <= 1'b1;
    end else begin
      rx_out_reg   <= rx_out_next; // [RULE3]
      rx_oe_reg    <= rx_oe_next;
      uart_rxd_reg <= (rx_mode == OPM_RX_UART) ? (rx_sync ^ rx_inv) : 1'b1; // [RULE4]
      third_rx_reg <= (rx_mode == OPM_RX_BITBANG) ? rx_sync : 1'b1; // [RULE1]
    end
  end

  assign optical_receive_pin_out = rx_out_reg;
  assign optical_receive_pin_oe  = rx_oe_reg;
  assign uart_rxd                = uart_rxd_reg;
  assign third_uart_gpio_in      = third_rx_reg;
  // gpio view never sees the uart inversion
  assign receive_pin_gpio_in     = rx_sync; // [RULE4]

  assign status_word = {5'h00, cif.carrier, tx_out_reg, rx_sync};

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_bitbang_rx_path: assert property ( // [RULE1]
    @(posedge clk) disable iff (!resetn)
    $past(rx_bb && !rx_dis && !seg_rx) |->
      uart_rxd && (third_uart_gpio_in == $past(rx_sync)) && !optical_receive_pin_oe)
    else $error("bit-bang mode did not hand the receive input to gpio");

  chk_rx_segment_drive: assert property ( // [RULE3]
    @(posedge clk) disable iff (!resetn)
    $past(seg_rx) |->
      optical_receive_pin_oe && (optical_receive_pin_out == $past(receive_pin_segment)) && uart_rxd)
    else $error("receive pin not driven as segment");

  chk_rx_uart_release: assert property ( // [RULE3]
    @(posedge clk) disable iff (!resetn)
    $past(!seg_rx && !rx_dis) |-> !optical_receive_pin_oe)
    else $error("receive pin driven while used as input");

  chk_rx_invert_uart: assert property ( // [RULE4]
    @(posedge clk) disable iff (!resetn)
    $past(resetn) && $past(!seg_rx && !rx_dis && !rx_bb) |-> (uart_rxd == ($past(rx_sync) ^ $past(rx_inv))))
    else $error("uart receive value does not follow inversion setting");

  chk_tx_pulse_route: assert property ( // [RULE5]
    @(posedge clk) disable iff (!resetn)
    !seg_tx && tx_route[1] |=>
      optical_transmit_pin_oe &&
      (optical_transmit_pin_out == ($past(tx_route[0]) ? !$past(voltage_pulse) ^ $past(pls_pol)
                                                       : !$past(real_energy_pulse) ^ $past(pls_pol))))
    else $error("transmit pin does not carry the selected pulse");

  chk_tx_segment_route: assert property ( // [RULE5]
    @(posedge clk) disable iff (!resetn)
    seg_tx |=> optical_transmit_pin_oe && (optical_transmit_pin_out == $past(transmit_pin_segment)))
    else $error("transmit pin not driven as segment");

  chk_tx_invert_plain: assert property ( // [RULE6]
    @(posedge clk) disable iff (!resetn)
    !seg_tx && (tx_route == OPM_ROUTE_UART) && !tx_mod |=>
      optical_transmit_pin_out == ($past(uart_txd) ^ $past(tx_inv)))
    else $error("unmodulated transmit does not follow inversion");

  chk_tx_modulate_gap: assert property ( // [RULE7]
    @(posedge clk) disable iff (!resetn)
    !seg_tx && (tx_route == OPM_ROUTE_UART) && tx_mod |=>
      optical_transmit_pin_out == (($past(uart_txd) ^ $past(tx_inv)) ? 1'b1 : $past(cif.carrier)))
    else $error("modulated transmit wrong in zero or one interval");

  chk_pulse_polarity_default: assert property ( // [RULE8]
    @(posedge clk) disable iff (!resetn)
    !seg_tx && (tx_route == OPM_ROUTE_REAL) && !pls_pol && !real_energy_pulse |=> optical_transmit_pin_out)
    else $error("idle energy pulse not high with default polarity");

  chk_read_latency: assert property (
    @(posedge clk) disable iff (!resetn)
    reg_read && sel_tx_cfg ##1 !reg_read |-> (reg_rdata == $past(tx_cfg_reg)) ##1 (reg_rdata == 8'h00))
    else $error("read data not in the single cycle after the strobe");

endmodule

// [rtl/opm_pkg.sv]
package opm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register bus
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;

  localparam logic [15:0] OPM_TX_CFG_ADDR    = 16'h2456;
  localparam logic [15:0] OPM_RX_CFG_ADDR    = 16'h2457;
  localparam logic [15:0] OPM_PULSE_CFG_ADDR = 16'h210c;
  localparam logic [15:0] OPM_SEG_MAP_ADDR   = 16'h2460;
  localparam logic [15:0] OPM_STATUS_ADDR    = 16'h2461;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int unsigned TX_INV_BIT     = 0;
  localparam int unsigned TX_MOD_BIT     = 1;
  localparam int unsigned TX_ROUTE_LSB   = 2;
  localparam int unsigned RX_BB_BIT      = 0;
  localparam int unsigned RX_INV_BIT     = 1;
  localparam int unsigned RX_DIS_BIT     = 2;
  localparam int unsigned RX_DUTY_LSB    = 4;
  localparam int unsigned PLS_POL_BIT    = 0;
  localparam int unsigned SEG_TX_BIT     = 0;
  localparam int unsigned SEG_RX_BIT     = 1;
  localparam int unsigned ST_RX_PIN_BIT  = 0;
  localparam int unsigned ST_TX_PIN_BIT  = 1;
  localparam int unsigned ST_CARRIER_BIT = 2;

  // writable bits; the rest read as zero
  localparam logic [7:0] TX_CFG_MASK    = 8'h0f;
  localparam logic [7:0] RX_CFG_MASK    = 8'h37;
  localparam logic [7:0] PULSE_CFG_MASK = 8'h01;
  localparam logic [7:0] SEG_MAP_MASK   = 8'h03;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] TX_CFG_RST    = 8'h00;
  localparam logic [7:0] RX_CFG_RST    = 8'h00;
  localparam logic [7:0] PULSE_CFG_RST = 8'h00;
  localparam logic [7:0] SEG_MAP_RST   = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // carrier timing; period must be exactly 16 cycles, a power of two that fills the 4-bit counter
  localparam int unsigned CLK_PERIOD_NS      = 10;
  localparam int unsigned CARRIER_PERIOD_NS  = 160;
  localparam int unsigned CARRIER_PERIOD_CYC = CARRIER_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned CARRIER_CNT_W      = 4;

  ////////////////////////////////////////////////////////////////////////////
  // modes
  typedef enum logic [1:0] {
    OPM_ROUTE_GPIO  = 2'b00,
    OPM_ROUTE_UART  = 2'b01,
    OPM_ROUTE_REAL  = 2'b10,
    OPM_ROUTE_VOLT  = 2'b11
  } opm_route_t;

  typedef enum logic [1:0] {
    OPM_RX_UART     = 2'b00,
    OPM_RX_GPIO     = 2'b01,
    OPM_RX_SEGMENT  = 2'b10,
    OPM_RX_BITBANG  = 2'b11
  } opm_rx_mode_t;

endpackage

// [rtl/opm_carrier_if.sv]
`timescale 1ns/1ps
interface opm_carrier_if;
  logic [1:0] duty_sel;
  logic       carrier;

  modport gen  (input  duty_sel, output carrier);
  modport user (output duty_sel, input  carrier);
endinterface

// [rtl/opm_sync.sv]
`timescale 1ns/1ps
module opm_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // level crossing
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// [rtl/opm_carrier.sv]
`timescale 1ns/1ps
module opm_carrier
  import opm_pkg::*;
#(
  parameter int unsigned PERIOD = CARRIER_PERIOD_CYC
) (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  resetn,
  // duty select in, carrier out
  opm_carrier_if.gen cif
);

  localparam logic [CARRIER_CNT_W:0] PERIOD_W = (CARRIER_CNT_W + 1)'(PERIOD);

  logic [CARRIER_CNT_W-1:0] cnt_reg;
  logic [CARRIER_CNT_W-1:0] cnt_next;
  logic [CARRIER_CNT_W:0]   low_cnt;
  logic                     at_end;

  // low part first, then high for the rest of the period
  assign low_cnt     = PERIOD_W >> ({1'b0, cif.duty_sel} + 3'h1); // [RULE2]
  assign at_end      = ({1'b0, cnt_reg} == PERIOD_W - 1'b1);
  assign cnt_next    = at_end ? '0 : cnt_reg + 1'b1; // [RULE9]
  assign cif.carrier = ({1'b0, cnt_reg} >= low_cnt); // [RULE2]

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [CARRIER_CNT_W:0] low_run_reg;
  logic [1:0]             duty_prev_reg;
  logic                   dirty_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      low_run_reg   <= '0;
      duty_prev_reg <= 2'h0;
      dirty_reg     <= 1'b0;
    end else begin
      low_run_reg   <= cif.carrier ? '0 : low_run_reg + 1'b1;
      duty_prev_reg <= cif.duty_sel;
      dirty_reg     <= cif.carrier ? 1'b0 : (dirty_reg | (cif.duty_sel != duty_prev_reg));
    end
  end

  chk_duty_low_run: assert property ( // [RULE2]
    @(posedge clk) disable iff (!resetn)
    $rose(cif.carrier) && !dirty_reg && $stable(cif.duty_sel) |->
      low_run_reg == (PERIOD_W >> ({1'b0, cif.duty_sel} + 3'h1)))
    else $error("carrier low time does not match duty select");

  chk_carrier_period_wrap: assert property ( // [RULE9]
    @(posedge clk) disable iff (!resetn)
    at_end |=> (cnt_reg == '0) ##1 (cnt_reg == 1))
    else $error("carrier divider does not wrap at its period");

endmodule

// [testbench/opm_ir_partner.sv]
`timescale 1ns/1ps
module opm_ir_partner (
  // photodetector side
  input  wire logic light,
  // led drive
  input  wire logic tx_out,
  input  wire logic tx_oe,
  // port drive on the receive wire
  input  wire logic rx_out,
  input  wire logic rx_oe,
  // resolved levels
  output logic      rx_wire,
  output logic      led_on
);
  // port drive overrides the comparator while enabled; otherwise the light decides
  assign rx_wire = rx_oe ? rx_out : light;
  // an undriven led stays dark
  assign led_on  = tx_oe & tx_out;
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import opm_pkg::*;

  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [7:0]  reg_rdata;
  logic        uart_txd = 1'b0;
  logic        real_energy_pulse = 1'b0;
  logic        voltage_pulse = 1'b0;
  logic        transmit_pin_gpio_out = 1'b0;
  logic        transmit_pin_gpio_oe = 1'b0;
  logic        transmit_pin_segment = 1'b0;
  logic        optical_transmit_pin_out;
  logic        optical_transmit_pin_oe;
  logic        optical_receive_pin_in;
  logic        optical_receive_pin_out;
  logic        optical_receive_pin_oe;
  logic        receive_pin_gpio_out = 1'b0;
  logic        receive_pin_gpio_oe = 1'b0;
  logic        receive_pin_segment = 1'b0;
  logic        receive_pin_gpio_in;
  logic        uart_rxd;
  logic        third_uart_gpio_in;
  logic        light = 1'b0;
  logic        led_on;
  int          bad_count = 0;
  int          checked = 0;

  always #5 clk = ~clk;

  opm_port uut (
    .clk, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .uart_txd, .real_energy_pulse, .voltage_pulse, .transmit_pin_gpio_out,
    .transmit_pin_gpio_oe, .transmit_pin_segment, .optical_transmit_pin_out,
    .optical_transmit_pin_oe, .optical_receive_pin_in, .optical_receive_pin_out,
    .optical_receive_pin_oe, .receive_pin_gpio_out, .receive_pin_gpio_oe,
    .receive_pin_segment, .receive_pin_gpio_in, .uart_rxd, .third_uart_gpio_in
  );

  opm_ir_partner ir (
    .light   (light),
    .tx_out  (optical_transmit_pin_out),
    .tx_oe   (optical_transmit_pin_oe),
    .rx_out  (optical_receive_pin_out),
    .rx_oe   (optical_receive_pin_oe),
    .rx_wire (optical_receive_pin_in),
    .led_on  (led_on)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    if (bad_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [15:0] a [4];
    logic [7:0]  m [4];
    logic [7:0]  r [4];
    logic [7:0]  d;
    a = '{OPM_TX_CFG_ADDR, OPM_RX_CFG_ADDR, OPM_PULSE_CFG_ADDR, OPM_SEG_MAP_ADDR};
    m = '{TX_CFG_MASK, RX_CFG_MASK, PULSE_CFG_MASK, SEG_MAP_MASK};
    r = '{TX_CFG_RST, RX_CFG_RST, PULSE_CFG_RST, SEG_MAP_RST};
    for (int i = 0; i < 4; i++) begin
      rd(a[i], d);
      check("reset value", d, r[i]);
      wr(a[i], 8'hff);
      rd(a[i], d);
      check("writable bits", d, m[i]);
      settle(1);
      check("rdata idle", reg_rdata, 8'h00);
      wr(a[i], 8'h00);
    end
    // unmapped place swallows writes
    wr(16'h2458, 8'hff);
    rd(16'h2458, d);
    check("unmapped read", d, 8'h00);
  endtask

  task automatic t_route;
    logic e_out;
    logic e_oe;
    for (int pol = 0; pol < 2; pol++) begin
      wr(OPM_PULSE_CFG_ADDR, 8'(pol));
      for (int r = 0; r < 4; r++) begin
        wr(OPM_TX_CFG_ADDR, 8'(r << TX_ROUTE_LSB));
        for (int v = 0; v < 8; v++) begin
          @(posedge clk);
          uart_txd              <= v[0];
          real_energy_pulse     <= v[1];
          voltage_pulse         <= v[2];
          transmit_pin_gpio_out <= ~v[0];
          transmit_pin_gpio_oe  <= v[1];
          settle(1);
          case (r)
            0: e_out = ~v[0];
            1: e_out = v[0];
            2: e_out = (pol == 1) ? v[1] : ~v[1];
            default: e_out = (pol == 1) ? v[2] : ~v[2];
          endcase
          e_oe = (r == 0) ? v[1] : 1'b1;
          check("tx pin out", 8'(optical_transmit_pin_out), 8'(e_out));
          check("tx pin oe", 8'(optical_transmit_pin_oe), 8'(e_oe));
        end
      end
    end
    // segment map wins over the voltage-pulse route still selected from the loop above
    wr(OPM_SEG_MAP_ADDR, 8'h01);
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      transmit_pin_segment <= v[0];
      uart_txd             <= ~v[0];
      settle(1);
      check("tx segment out", 8'(optical_transmit_pin_out), 8'(v[0]));
      check("tx segment oe", 8'(optical_transmit_pin_oe), 8'h01);
    end
    wr(OPM_SEG_MAP_ADDR, 8'h00);
    wr(OPM_PULSE_CFG_ADDR, 8'h00);
  endtask

  // counting lows over one full period makes the result independent of carrier phase
  task automatic t_mod;
    int   lows;
    int   exp;
    logic sig;
    for (int c = 0; c < 32; c++) begin
      @(posedge clk);
      uart_txd <= c[1];
      wr(OPM_TX_CFG_ADDR, {4'h0, 2'b01, c[2], c[0]});
      wr(OPM_RX_CFG_ADDR, {2'b00, c[4:3], 4'h0});
      settle(2);
      lows = 0;
      repeat (CARRIER_PERIOD_CYC) begin
        if (led_on === 1'b0) lows++;
        settle(1);
      end
      sig = c[1] ^ c[0];
      exp = sig ? 0 : (c[2] ? (CARRIER_PERIOD_CYC >> (c[4:3] + 1)) : CARRIER_PERIOD_CYC);
      check("carrier low cycles", 8'(lows), 8'(exp));
    end
    wr(OPM_TX_CFG_ADDR, 8'h00);
    wr(OPM_RX_CFG_ADDR, 8'h00);
  endtask

  task automatic t_rx;
    logic [7:0] cfg;
    logic       seg;
    logic       goe;
    logic       lb;
    logic       drive;
    logic       e_g;
    logic       e_u;
    logic       e_t;
    logic [7:0] d;
    for (int m = 0; m < 6; m++) begin
      for (int l = 0; l < 2; l++) begin
        cfg = 8'h00;
        seg = 1'b0;
        goe = 1'b0;
        case (m)
          1: cfg = 8'h02;
          2: cfg = 8'h04;
          3: cfg = 8'h01;
          4: seg = 1'b1;
          5: begin
            cfg = 8'h04;
            goe = 1'b1;
          end
          default: cfg = 8'h00;
        endcase
        lb    = l[0];
        drive = (m >= 4);
        wr(OPM_RX_CFG_ADDR, cfg);
        wr(OPM_SEG_MAP_ADDR, {6'h00, seg, 1'b0});
        @(posedge clk);
        light                <= lb;
        receive_pin_segment  <= ~lb;
        receive_pin_gpio_out <= ~lb;
        receive_pin_gpio_oe  <= goe;
        settle(4);
        e_g = drive ? ~lb : lb;
        e_u = (m == 0) ? lb : ((m == 1) ? ~lb : 1'b1);
        e_t = (m == 3) ? lb : 1'b1;
        check("rx gpio in", 8'(receive_pin_gpio_in), 8'(e_g));
        check("rx pin oe", 8'(optical_receive_pin_oe), 8'(drive));
        check("uart rxd", 8'(uart_rxd), 8'(e_u));
        check("third uart in", 8'(third_uart_gpio_in), 8'(e_t));
        if (drive) check("rx pin out", 8'(optical_receive_pin_out), {7'h00, ~lb});
        // status shows the synchronised pin, never the uart inversion
        rd(OPM_STATUS_ADDR, d);
        check("status rx pin", 8'(d[ST_RX_PIN_BIT]), 8'(e_g));
      end
    end
    wr(OPM_RX_CFG_ADDR, 8'h00);
    wr(OPM_SEG_MAP_ADDR, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    t_regs;
    t_route;
    t_mod;
    t_rx;
    summarize;
  end

  // cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    summarize;
  end
endmodule
